/* logic/dma_pkg.sv */
// shared constants and carrier types for the dma channel block
package dma_pkg;
    localparam int addr_width = 24;
    localparam int count_width = 16;
    localparam int irq_count = 11;
    localparam logic [15:0] count_zero = 16'h0000;
    localparam logic [23:0] addr_reset = 24'h000000;
    localparam logic [7:0] byte_zero = 8'h00;
    localparam logic [23:0] step_byte = 24'h000001;
    localparam logic [23:0] step_word = 24'h000002;
    localparam logic [23:0] internal_top = 24'h00FFFF;

    typedef enum logic [1:0] {
        step_fixed = 2'h0,
        step_inc = 2'h1,
        step_dec = 2'h2
    } step_mode_type;

    typedef enum logic [1:0] {
        src_internal = 2'h0,
        src_edge = 2'h1,
        src_level = 2'h2,
        src_auto = 2'h3
    } source_type;

    typedef struct packed {
        logic channel_enable_bit;
        logic end_interrupt_enable_bit;
        logic full_address;
        logic channel_b;
        logic block_mode;
        logic burst;
        logic single_address;
        logic single_write_dir;
        logic word_size;
        logic block_side_select;
        logic source_owner_select_bit;
        source_type source;
        logic [3:0] irq_select;
        step_mode_type src_step;
        step_mode_type dst_step;
    } config_type;

    typedef struct packed {
        logic [23:0] addr;
        logic addr_drive;
        logic read;
        logic write;
        logic addr_strobe;
    } bus_cycle_type;
endpackage

/* logic/dma_channel.sv */
// one dma channel: activation, counting, addressing and bus cycles
`timescale 1ns/1ns
module dma_channel (
    input wire logic clk,
    input wire logic resetn,
    input wire dma_pkg::config_type cfg,
    input wire logic start,
    input wire logic [23:0] src_init,
    input wire logic [23:0] dst_init,
    input wire logic [15:0] count_init,
    input wire logic [7:0] block_size_init,
    input wire logic [dma_pkg::irq_count-1:0] irq_in,
    input wire logic request_pin_n,
    input wire logic bus_grant,
    output logic bus_request,
    output dma_pkg::bus_cycle_type bus_out,
    output logic acknowledge_strobe_n,
    output logic irq_flag_clear,
    output logic end_irq,
    output logic busy,
    output logic [15:0] block_count_reg,
    output logic [23:0] source_address_reg,
    output logic [23:0] destination_address_reg
);
    typedef enum logic [4:0] {
        st_idle = 5'h01,
        st_read = 5'h02,
        st_write = 5'h04,
        st_dead = 5'h08,
        st_single = 5'h10
    } state_type;

    state_type state_r, state_nxt;
    logic [23:0] src_r, src_nxt, dst_r, dst_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [7:0] bsize_r, bsize_nxt, bhold_r, bhold_nxt;
    logic en_r, en_nxt, pend_r, pend_nxt, irq_r, irq_nxt;
    logic ack_r, ack_nxt, clr_r, clr_nxt;
    logic gap_r, gap_nxt;
    dma_pkg::bus_cycle_type bus_r, bus_nxt;
    logic req_s1_r, req_s2_r, req_prev_r;
    logic ext_ok, int_ok, auto_ok, irq_hit, activate, last_unit, block_end;

    function automatic logic [23:0] step_addr(input logic [23:0] a,
            input dma_pkg::step_mode_type m, input logic word);
        logic [23:0] d;
        d = word ? dma_pkg::step_word : dma_pkg::step_byte;
        case (m)
            dma_pkg::step_inc: step_addr = a + d;
            dma_pkg::step_dec: step_addr = a - d;
            default: step_addr = a;
        endcase
    endfunction

    function automatic logic is_external(input logic [23:0] a);
        is_external = a > dma_pkg::internal_top;
    endfunction

    // request pin synchroniser, first stage read only by the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            req_s1_r <= 1'b1;
            req_s2_r <= 1'b1;
            req_prev_r <= 1'b1;
        end else begin
            req_s1_r <= request_pin_n;
            req_s2_r <= req_s1_r;
            req_prev_r <= req_s2_r;
        end
    end

    // external requests barred on a channels in short address mode
    assign ext_ok = cfg.full_address || cfg.channel_b;
    // auto request only in full address normal mode
    assign auto_ok = cfg.full_address && !cfg.block_mode;
    // internal sources barred in full address normal mode
    assign int_ok = !(cfg.full_address && !cfg.block_mode);
    assign irq_hit = irq_in[cfg.irq_select];
    assign last_unit = cfg.block_mode ? (bsize_r == 8'h01 && cnt_r == 16'h0001)
                                      : (cnt_r == 16'h0001);
    assign block_end = cfg.block_mode && bsize_r == 8'h01;

    always_comb begin
        pend_nxt = pend_r;
        case (cfg.source)
            // edge seen only while idle; edges mid transfer may be lost
            dma_pkg::src_edge:
                if (ext_ok && state_r == st_idle && req_prev_r && !req_s2_r)
                    pend_nxt = 1'b1;
            // level: wants a unit while pin low, none while high
            dma_pkg::src_level: pend_nxt = ext_ok && !req_s2_r;
            dma_pkg::src_internal: if (int_ok && irq_hit) pend_nxt = 1'b1;
            dma_pkg::src_auto: pend_nxt = auto_ok;
            default: pend_nxt = 1'b0;
        endcase
        if (!en_r) pend_nxt = 1'b0;
    end
    assign activate = en_r && pend_r;
    // bus kept across read-write, and between units only in burst or inside a block
    // request dropped for one cycle after a released unit, else the arbiter never switches
    assign bus_request = (state_r != st_idle) || (activate && !gap_r);
    assign busy = en_r;

    always_comb begin
        state_nxt = state_r;
        src_nxt = src_r;
        dst_nxt = dst_r;
        cnt_nxt = cnt_r;
        bsize_nxt = bsize_r;
        bhold_nxt = bhold_r;
        en_nxt = en_r;
        irq_nxt = 1'b0;
        ack_nxt = 1'b0;
        clr_nxt = 1'b0;
        gap_nxt = 1'b0;
        bus_nxt = '0;
        if (start) begin
            src_nxt = src_init;
            dst_nxt = dst_init;
            cnt_nxt = count_init;
            bsize_nxt = block_size_init;
            bhold_nxt = block_size_init;
            en_nxt = 1'b1;
            state_nxt = st_idle;
        end else begin
            case (state_r)
                st_idle:
                    if (activate && bus_grant && !gap_r) begin
                        // dual: read then write; single: one combined cycle
                        if (cfg.single_address) begin
                            state_nxt = st_single;
                            bus_nxt.addr = src_r;
                            bus_nxt.addr_drive = 1'b1;
                            bus_nxt.addr_strobe = 1'b1;
                            // memory written when data comes from device
                            bus_nxt.write = cfg.single_write_dir;
                            bus_nxt.read = !cfg.single_write_dir;
                            ack_nxt = 1'b1;
                        end else begin
                            state_nxt = st_read;
                            bus_nxt.addr = src_r;
                            bus_nxt.addr_drive = is_external(src_r);
                            bus_nxt.addr_strobe = is_external(src_r);
                            bus_nxt.read = 1'b1;
                        end
                    end
                st_read: begin
                    state_nxt = st_write;
                    bus_nxt.addr = dst_r;
                    bus_nxt.addr_drive = is_external(dst_r);
                    bus_nxt.addr_strobe = is_external(dst_r);
                    bus_nxt.write = 1'b1;
                end
                st_write, st_single: begin
                    // flag cleared only when not shared with cpu or controller
                    clr_nxt = cfg.source == dma_pkg::src_internal
                              && cfg.source_owner_select_bit;
                    // one side steps inside the block, other is the block area
                    src_nxt = step_addr(src_r, cfg.src_step, cfg.word_size);
                    dst_nxt = step_addr(dst_r, cfg.dst_step, cfg.word_size);
                    if (cfg.single_address) dst_nxt = dst_r;
                    if (cfg.block_mode) begin
                        bsize_nxt = bsize_r - 8'h01;
                        if (block_end) begin
                            bsize_nxt = bhold_r;
                            cnt_nxt = cnt_r - 16'h0001;
                            if (cfg.block_side_select) src_nxt = src_init;
                            else dst_nxt = dst_init;
                        end
                    end else begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                    if (last_unit) begin
                        state_nxt = st_dead;
                        en_nxt = 1'b0;
                        irq_nxt = cfg.end_interrupt_enable_bit;
                    end else if (cfg.burst && !cfg.block_mode && activate) begin
                        state_nxt = cfg.single_address ? st_single : st_read;
                        bus_nxt.addr = src_nxt;
                        bus_nxt.addr_drive = cfg.single_address || is_external(src_nxt);
                        bus_nxt.addr_strobe = bus_nxt.addr_drive;
                        bus_nxt.read = !(cfg.single_address && cfg.single_write_dir);
                        bus_nxt.write = cfg.single_address && cfg.single_write_dir;
                        ack_nxt = cfg.single_address;
                    end else if (cfg.block_mode && !block_end) begin
                        // whole block runs without letting go of the bus
                        state_nxt = cfg.single_address ? st_single : st_read;
                        bus_nxt.addr = src_nxt;
                        bus_nxt.addr_drive = cfg.single_address || is_external(src_nxt);
                        bus_nxt.addr_strobe = bus_nxt.addr_drive;
                        bus_nxt.read = !(cfg.single_address && cfg.single_write_dir);
                        bus_nxt.write = cfg.single_address && cfg.single_write_dir;
                        ack_nxt = cfg.single_address;
                    end else begin
                        state_nxt = st_idle;
                        gap_nxt = 1'b1;
                    end
                end
                st_dead: state_nxt = st_idle;
                default: state_nxt = st_idle;
            endcase
        end
    end

    // pending request dropped when a unit begins from idle, except for auto source; level source re-arms by itself
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) pend_r <= 1'b0;
        else if (state_r == st_idle && activate && bus_grant && !gap_r
                 && cfg.source != dma_pkg::src_auto)
            pend_r <= 1'b0;
        else pend_r <= pend_nxt;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= st_idle;
            src_r <= dma_pkg::addr_reset;
            dst_r <= dma_pkg::addr_reset;
            cnt_r <= dma_pkg::count_zero;
            bsize_r <= dma_pkg::byte_zero;
            bhold_r <= dma_pkg::byte_zero;
            en_r <= 1'b0;
            irq_r <= 1'b0;
            ack_r <= 1'b0;
            clr_r <= 1'b0;
            gap_r <= 1'b0;
            bus_r <= '0;
        end else begin
            state_r <= state_nxt;
            src_r <= src_nxt;
            dst_r <= dst_nxt;
            cnt_r <= cnt_nxt;
            bsize_r <= bsize_nxt;
            bhold_r <= bhold_nxt;
            en_r <= en_nxt;
            irq_r <= irq_nxt;
            ack_r <= ack_nxt;
            clr_r <= clr_nxt;
            gap_r <= gap_nxt;
            bus_r <= bus_nxt;
        end
    end

    assign bus_out = bus_r;
    assign acknowledge_strobe_n = !ack_r;
    assign irq_flag_clear = clr_r;
    assign end_irq = irq_r;
    assign block_count_reg = cnt_r;
    assign source_address_reg = src_r;
    assign destination_address_reg = dst_r;

    a_end_clears_enable: assert property (@(posedge clk) disable iff (!resetn)
        end_irq |-> !busy)
        else $error("enable still set after end interrupt");
    a_end_irq_gated: assert property (@(posedge clk) disable iff (!resetn)
        end_irq |-> cfg.end_interrupt_enable_bit && block_count_reg == 16'h0000)
        else $error("end interrupt without enable or zero count");
    a_ack_with_strobe: assert property (@(posedge clk) disable iff (!resetn)
        !acknowledge_strobe_n |-> bus_out.addr_strobe && cfg.single_address)
        else $error("acknowledge without address strobe");
    a_read_then_write: assert property (@(posedge clk) disable iff (!resetn)
        state_r == st_read && !start |=> state_r == st_write && bus_request)
        else $error("read not followed by write");
    a_dead_after_last: assert property (@(posedge clk) disable iff (!resetn)
        $rose(end_irq) |-> state_r == st_dead ##1 state_r == st_idle)
        else $error("no dead cycle after final write");
    a_no_internal_drive: assert property (@(posedge clk) disable iff (!resetn)
        bus_out.addr_drive && !cfg.single_address |-> is_external(bus_out.addr))
        else $error("internal address driven outside");
    a_steal_release: assert property (@(posedge clk) disable iff (!resetn)
        state_r == st_write && !cfg.burst && !cfg.block_mode && !start
        |=> state_r != st_read)
        else $error("cycle steal kept the bus");
    a_steal_gap: assert property (@(posedge clk) disable iff (!resetn)
        state_r == st_write && !cfg.burst && !cfg.block_mode && !last_unit && !start
        |=> !bus_request)
        else $error("bus request not dropped after stolen unit");
    a_auto_only_normal: assert property (@(posedge clk) disable iff (!resetn)
        cfg.source == dma_pkg::src_auto && !auto_ok |=> !pend_r)
        else $error("auto request outside full normal mode");
    a_ext_a_channel: assert property (@(posedge clk) disable iff (!resetn)
        cfg.source[1] != cfg.source[0] && !ext_ok |=> !pend_r)
        else $error("external request on a channel in short mode");
    c_end_seen: cover property (@(posedge clk) end_irq);
    c_single_cycle: cover property (@(posedge clk) !acknowledge_strobe_n);
    c_burst_run: cover property (@(posedge clk) state_r == st_write ##1 state_r == st_read);
endmodule

/* test/ext_side_model.sv */
// far side: bus arbiter with optional stall, plus bus cycle and acknowledge counters
`timescale 1ns/1ns
module ext_side_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic clr,
    input wire logic bus_request,
    input wire dma_pkg::bus_cycle_type bus_out,
    input wire logic acknowledge_strobe_n,
    output logic bus_grant,
    output int n_reads,
    output int n_writes,
    output int n_ext_reads,
    output int n_acks
);
    logic phase_r;
    // grant is registered so no loop forms through bus_request
    // once granted it is never revoked while still requested
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= 1'b0;
            bus_grant <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
            bus_grant <= bus_request && (bus_grant || !slow || phase_r);
        end
    end
    always_ff @(posedge clk) begin
        if (clr) begin
            n_reads <= 0;
            n_writes <= 0;
            n_ext_reads <= 0;
            n_acks <= 0;
        end else begin
            n_reads <= n_reads + (bus_out.read === 1'b1);
            n_writes <= n_writes + (bus_out.write === 1'b1);
            n_ext_reads <= n_ext_reads + (bus_out.read === 1'b1 && bus_out.addr_drive === 1'b1);
            n_acks <= n_acks + (acknowledge_strobe_n === 1'b0);
        end
    end
endmodule

/* test/dma_channel_tb_top.sv */
// testbench for the dma channel: one task per transfer mode or request source, plus one for a refused request
`timescale 1ns/1ns
module dma_channel_tb_top;
    logic clk, resetn, start, request_pin_n, slow, clr, req_q;
    dma_pkg::config_type cfg;
    logic [23:0] src_init, dst_init;
    logic [15:0] count_init;
    logic [7:0] block_size_init;
    logic [dma_pkg::irq_count-1:0] irq_in;
    logic bus_grant, bus_request, acknowledge_strobe_n, irq_flag_clear, end_irq, busy;
    dma_pkg::bus_cycle_type bus_out;
    logic [15:0] block_count_reg;
    logic [23:0] source_address_reg, destination_address_reg;
    int n_reads, n_writes, n_ext_reads, n_acks, n_errors, n_checks, cycles;
    int n_end, n_clr, n_drop, n_ack_bad;
    dma_channel u_dma_channel (.clk(clk), .resetn(resetn), .cfg(cfg), .start(start),
        .src_init(src_init), .dst_init(dst_init), .count_init(count_init),
        .block_size_init(block_size_init), .irq_in(irq_in), .request_pin_n(request_pin_n),
        .bus_grant(bus_grant), .bus_request(bus_request), .bus_out(bus_out),
        .acknowledge_strobe_n(acknowledge_strobe_n), .irq_flag_clear(irq_flag_clear),
        .end_irq(end_irq), .busy(busy), .block_count_reg(block_count_reg),
        .source_address_reg(source_address_reg),
        .destination_address_reg(destination_address_reg));
    ext_side_model u_ext_side_model (.clk(clk), .resetn(resetn), .slow(slow), .clr(clr),
        .bus_request(bus_request), .bus_out(bus_out),
        .acknowledge_strobe_n(acknowledge_strobe_n), .bus_grant(bus_grant),
        .n_reads(n_reads), .n_writes(n_writes), .n_ext_reads(n_ext_reads), .n_acks(n_acks));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        req_q <= bus_request;
        if (clr) begin
            n_end <= 0;
            n_clr <= 0;
            n_drop <= 0;
            n_ack_bad <= 0;
        end else begin
            n_end <= n_end + (end_irq === 1'b1);
            n_clr <= n_clr + (irq_flag_clear === 1'b1);
            n_drop <= n_drop + (req_q === 1'b1 && bus_request === 1'b0 && busy === 1'b1);
            n_ack_bad <= n_ack_bad + (acknowledge_strobe_n === 1'b0 && bus_out.addr_strobe !== 1'b1);
        end
    end
    always @(posedge clk) begin
        if (cycles == 8000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic dma_pkg::config_type base();
        dma_pkg::config_type c;
        c = '0;
        c.channel_enable_bit = 1'b1;
        c.end_interrupt_enable_bit = 1'b1;
        c.full_address = 1'b1;
        c.channel_b = 1'b1;
        c.source = dma_pkg::src_auto;
        c.src_step = dma_pkg::step_inc;
        c.dst_step = dma_pkg::step_inc;
        return c;
    endfunction
    task automatic wait_idle(input int lim);
        int k;
        k = 0;
        while (busy !== 1'b0 && k < lim) begin
            @(negedge clk);
            k++;
        end
        // one more edge so the last unit's one-cycle pulses get counted
        @(negedge clk);
    endtask
    // counters are cleared on the same edge that takes start
    task automatic run(input dma_pkg::config_type c, input logic [23:0] src,
            input logic [15:0] n, input int lim);
        @(negedge clk);
        cfg = c;
        src_init = src;
        count_init = n;
        clr = 1'b1;
        start = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        start = 1'b0;
        wait_idle(lim);
    endtask
    task automatic pin_fall(input int gap);
        request_pin_n = 1'b0;
        repeat (3) @(negedge clk);
        request_pin_n = 1'b1;
        repeat (gap) @(negedge clk);
    endtask
    task automatic t_auto();
        dma_pkg::config_type c;
        c = base();
        c.word_size = 1'b1;
        c.dst_step = dma_pkg::step_dec;
        slow = 1'b1;
        run(c, 24'h001000, 16'h0003, 300);
        slow = 1'b0;
        chk(source_address_reg, 32'h00001006);
        chk(destination_address_reg, 32'h001FFFFA);
        chk(n_writes, 32'h00000003);
        chk(n_ext_reads, 32'h00000000);
        chk(n_end, 32'h00000001);
        chk(busy, 32'h00000000);
        chk(n_drop, 32'h00000002);
    endtask
    task automatic t_burst();
        dma_pkg::config_type c;
        c = base();
        c.burst = 1'b1;
        c.end_interrupt_enable_bit = 1'b0;
        c.src_step = dma_pkg::step_fixed;
        run(c, 24'h001000, 16'h0004, 300);
        chk(source_address_reg, 32'h00001000);
        chk(destination_address_reg, 32'h00200004);
        chk(n_drop, 32'h00000000);
        chk(n_end, 32'h00000000);
    endtask
    task automatic t_block(input int idx, input logic owner);
        dma_pkg::config_type c;
        c = base();
        c.block_mode = 1'b1;
        c.source = dma_pkg::src_internal;
        c.irq_select = 4'(idx);
        c.source_owner_select_bit = owner;
        c.block_side_select = owner;
        irq_in = '0;
        irq_in[idx] = 1'b1;
        run(c, 24'h001000, 16'h0002, 300);
        irq_in = '0;
        chk(n_reads, 32'h00000004);
        chk(block_count_reg, 32'h00000000);
        chk(busy, 32'h00000000);
        chk(source_address_reg, owner ? 32'h00001000 : 32'h00001004);
        chk(destination_address_reg, owner ? 32'h00200004 : 32'h00200000);
        chk(n_end, 32'h00000001);
        if (!owner)
            chk(n_clr, 32'h00000000);
        else if (idx >= 5)
            chk(n_clr, 32'h00000004);
    endtask
    task automatic t_edge();
        dma_pkg::config_type c;
        c = base();
        c.full_address = 1'b0;
        c.source = dma_pkg::src_edge;
        run(c, 24'h001000, 16'h0002, 0);
        pin_fall(30);
        chk(n_reads, 32'h00000001);
        chk(busy, 32'h00000001);
        pin_fall(30);
        chk(n_reads, 32'h00000002);
        chk(busy, 32'h00000000);
    endtask
    task automatic t_level();
        dma_pkg::config_type c;
        c = base();
        c.source = dma_pkg::src_level;
        run(c, 24'h001000, 16'h0003, 30);
        chk(n_reads, 32'h00000000);
        request_pin_n = 1'b0;
        wait_idle(200);
        request_pin_n = 1'b1;
        chk(n_reads, 32'h00000003);
        chk(busy, 32'h00000000);
    endtask
    task automatic t_single(input logic dir);
        dma_pkg::config_type c;
        c = base();
        c.single_address = 1'b1;
        c.single_write_dir = dir;
        // memory side kept in external space
        run(c, 24'h300000, 16'h0002, 300);
        chk(n_acks, 32'h00000002);
        chk(n_writes, dir ? 32'h00000002 : 32'h00000000);
        chk(n_ack_bad, 32'h00000000);
        chk(n_end, 32'h00000001);
    endtask
    task automatic t_refused();
        dma_pkg::config_type c;
        c = base();
        c.full_address = 1'b0;
        c.channel_b = 1'b0;
        c.source = dma_pkg::src_edge;
        run(c, 24'h001000, 16'h0001, 0);
        pin_fall(30);
        chk(n_reads, 32'h00000000);
        chk(busy, 32'h00000001);
    endtask
    initial begin
        resetn = 1'b0;
        start = 1'b0;
        clr = 1'b1;
        slow = 1'b0;
        request_pin_n = 1'b1;
        cfg = '0;
        src_init = '0;
        dst_init = 24'h200000;
        count_init = '0;
        block_size_init = 8'h02;
        irq_in = '0;
        cycles = 0;
        n_errors = 0;
        n_checks = 0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        t_auto();
        t_burst();
        for (int i = 0; i < dma_pkg::irq_count; i++) begin
            t_block(i, 1'(i % 2));
        end
        t_block(6, 1'b0);
        t_edge();
        t_level();
        t_single(1'b0);
        t_single(1'b1);
        t_refused();
        complete_run();
    end
endmodule
